// >>> design/apr_pair_sel.v
`timescale 1ns/1ps
`include "apr_regs.vh"

module apr_pair_sel
(
  input  wire                        clk,
  input  wire                        reset_n,
  input  wire                        pair_strobe,
  input  wire [1:0]                  cfg_type,
  input  wire [2:0]                  cfg_idx,
  input  wire [`APR_NCH*`APR_SW-1:0] sdi_in,
  input  wire [`APR_NCH*`APR_SW-1:0] aes_in,
  input  wire [`APR_ANA_CH*`APR_SW-1:0] ana_in,
  input  wire [`APR_DEC_CH*`APR_SW-1:0] dec_in,
  output reg  [1:0]                  act_type_r,
  output reg  [2:0]                  act_idx_r,
  output reg  [`APR_SW-1:0]          ch_lo_r,
  output reg  [`APR_SW-1:0]          ch_hi_r
);

  reg [2*`APR_SW-1:0] pick_nxt;

  // four-way source mux, one whole pair at a time
  always @*
  begin
    case (cfg_type)
      `APR_SRC_SDI: pick_nxt = sdi_in[cfg_idx*2*`APR_SW +: 2*`APR_SW];
      `APR_SRC_AES: pick_nxt = aes_in[cfg_idx*2*`APR_SW +: 2*`APR_SW]; // [RULE_12]
      `APR_SRC_ANA: pick_nxt = ana_in[cfg_idx[0]*2*`APR_SW +: 2*`APR_SW];
      `APR_SRC_DEC: pick_nxt = dec_in[cfg_idx[1:0]*2*`APR_SW +: 2*`APR_SW];
      default:      pick_nxt = {2*`APR_SW{1'b0}};
    endcase
  end

  // config and both samples change together on the pair boundary
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      act_type_r <= `APR_SRC_SDI;
      act_idx_r  <= 3'h0;
      ch_lo_r    <= {`APR_SW{1'b0}};
      ch_hi_r    <= {`APR_SW{1'b0}};
    end
    else if (pair_strobe)
    begin
      act_type_r <= cfg_type; // [RULE_16]
      act_idx_r  <= cfg_idx;
      ch_lo_r    <= pick_nxt[`APR_SW-1:0]; // [RULE_14]
      ch_hi_r    <= pick_nxt[2*`APR_SW-1:`APR_SW];
    end
  end

endmodule

// >>> design/apr_regs.vh
`ifndef APR_REGS_VH
`define APR_REGS_VH

// sample and lane geometry
`define APR_SW            24
`define APR_NCH           16
`define APR_NPAIR         8
`define APR_ANA_CH        4
`define APR_DEC_CH        8

// apb register byte offsets and page numbers
`define APR_OFS_CTRL      12'h000
`define APR_OFS_STATUS    12'h004
`define APR_OFS_LEVEL_EN  12'h008
`define APR_OFS_DATA_MODE 12'h00c
`define APR_PAGE_SEL      8'h01
`define APR_PAGE_GAIN     8'h02
`define APR_PAGE_ASSIGN   6'h01

// control register fields
`define APR_CTRL_SWITCH   0

// selector group register fields, two selectors per word
`define APR_SEL0_TYPE_LSB 0
`define APR_SEL0_IDX_LSB  2
`define APR_SEL1_TYPE_LSB 8
`define APR_SEL1_IDX_LSB  10

// source type codes
`define APR_SRC_SDI       2'h0
`define APR_SRC_AES       2'h1
`define APR_SRC_ANA       2'h2
`define APR_SRC_DEC       2'h3

// legal pair counts per source
`define APR_SDI_PAIRS     4'h8
`define APR_ANA_PAIRS     4'h2
`define APR_DEC_PAIRS     4'h4

// reset values and gain scaling shift
`define APR_SEL_IDX_RST   24'hfac688
`define APR_GAIN_UNITY    8'h80
`define APR_GAIN_SHIFT    7

`endif

// >>> design/apr_router.v
// Function
// [RULE_01] channel level control acts only when the global switch is also on
// [RULE_02] mixer output pair N feeds embedded out pair N and AES out pair N
// [RULE_03] an AES connector used as input is never driven as output
// [RULE_04] AES outputs and analog outputs carry mixer output together
// [RULE_05] every mixer input pair has a four-way source type selector
// [RULE_06] selectors form four identical groups of two pair selectors
// [RULE_07] embedded source offers pairs 1/2 through 15/16
// [RULE_08] AES source offers eight pairs full, six pairs on reduced variant
// [RULE_09] analog source offers only pairs 1/2 and 3/4
// [RULE_10] decoder source offers pairs 1/2 through 7/8
// [RULE_11] decoder gives six or eight channels; unused pairs carry silence
// [RULE_12] each AES connector carries one two-channel stream as one pair
// [RULE_13] deembedding and embedding run together for in-line remapping
// [RULE_14] first channel goes to lower mixer input, second to higher
// [RULE_15] legal pair indices depend on source type; illegal ones rejected
// [RULE_16] source changes take effect only on a sample-pair boundary
// [RULE_17] 16 inputs, 16 buses, default input N to bus N, any assignment
// [RULE_18] gain applied only per input channel, no bus gain
// [RULE_19] data-marked input pair bypasses mixing, bits unaltered
`timescale 1ns/1ps
`include "apr_regs.vh"

module apr_router
#(
  parameter AES_PAIRS = 8
)
(
  input  wire                           clk,
  input  wire                           reset_n,
  input  wire                           psel,
  input  wire                           penable,
  input  wire                           pwrite,
  input  wire [11:0]                    paddr,
  input  wire [31:0]                    pwdata,
  output reg  [31:0]                    prdata,
  output wire                           pready,
  output wire                           pslverr,
  input  wire                           pair_strobe,
  input  wire                           dec_eight_ch,
  input  wire [`APR_NCH*`APR_SW-1:0]    sdi_in,
  input  wire [`APR_NCH*`APR_SW-1:0]    aes_in,
  input  wire [`APR_ANA_CH*`APR_SW-1:0] ana_in,
  input  wire [`APR_DEC_CH*`APR_SW-1:0] dec_in,
  output reg  [`APR_NCH*`APR_SW-1:0]    emb_out,
  output reg  [`APR_NCH*`APR_SW-1:0]    aes_out,
  output reg  [`APR_NPAIR-1:0]          aes_oe,
  output reg  [`APR_ANA_CH*`APR_SW-1:0] ana_out,
  output reg                            out_strobe,
  output reg  [`APR_NCH-1:0]            level_ctrl_active
);

  localparam [3:0] AES_LIM = AES_PAIRS[3:0];

  reg                           global_level_ctrl_switch_r;
  reg  [`APR_NCH-1:0]           channel_level_ctrl_enable_r;
  reg  [`APR_NPAIR-1:0]         data_mode_r;
  reg  [2*`APR_NPAIR-1:0]       sel_type_r;
  reg  [3*`APR_NPAIR-1:0]       sel_idx_r;
  reg  [8*`APR_NCH-1:0]         gain_r;
  reg  [`APR_NCH*`APR_NCH-1:0]  assign_r;
  reg                           strobe_d_r;
  reg  [`APR_DEC_CH*`APR_SW-1:0] dec_gated;
  reg  [`APR_NCH*`APR_SW-1:0]   mix_out;
  reg  [`APR_NPAIR-1:0]         aes_used;
  reg  [31:0]                   rd_nxt;
  reg  signed [39:0]            acc;
  reg  signed [39:0]            prod;
  wire [1:0]                    grp;
  wire                          setup;
  wire                          access;
  wire                          sel_hit;
  wire                          gain_hit;
  wire                          asg_hit;
  wire                          ok0;
  wire                          ok1;
  wire [2*`APR_NPAIR-1:0]       act_type;
  wire [3*`APR_NPAIR-1:0]       act_idx;
  wire [`APR_NCH*`APR_SW-1:0]   mix_in;
  integer                       i;
  integer                       j;
  integer                       m;
  integer                       r;
  integer                       b;

  // legal pair index set for each source type
  function legal;
    input [1:0] typ;
    input [2:0] idx;
    input [3:0] aes_lim;
    begin
      case (typ)
        `APR_SRC_SDI: legal = ({1'b0, idx} < `APR_SDI_PAIRS); // [RULE_07]
        `APR_SRC_AES: legal = ({1'b0, idx} < aes_lim); // [RULE_08]
        `APR_SRC_ANA: legal = ({1'b0, idx} < `APR_ANA_PAIRS); // [RULE_09]
        `APR_SRC_DEC: legal = ({1'b0, idx} < `APR_DEC_PAIRS); // [RULE_10]
        default:      legal = 1'b0;
      endcase
    end
  endfunction

  // apb decode, zero wait states
  assign pready   = 1'b1;
  assign setup    = psel & ~penable;
  assign access   = psel & penable;
  assign grp      = paddr[3:2];
  assign sel_hit  = (paddr[11:4] == `APR_PAGE_SEL);
  assign gain_hit = (paddr[11:4] == `APR_PAGE_GAIN);
  assign asg_hit  = (paddr[11:6] == `APR_PAGE_ASSIGN);
  assign ok0 = legal(pwdata[`APR_SEL0_TYPE_LSB +: 2], pwdata[`APR_SEL0_IDX_LSB +: 3], AES_LIM);
  assign ok1 = legal(pwdata[`APR_SEL1_TYPE_LSB +: 2], pwdata[`APR_SEL1_IDX_LSB +: 3], AES_LIM);
  assign pslverr = access & pwrite & sel_hit & ~(ok0 & ok1); // [RULE_15]

  // register writes; illegal selector half keeps its old value
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      global_level_ctrl_switch_r  <= 1'b0;
      channel_level_ctrl_enable_r <= {`APR_NCH{1'b0}};
      data_mode_r                 <= {`APR_NPAIR{1'b0}};
      sel_type_r                  <= {2*`APR_NPAIR{1'b0}};
      sel_idx_r                   <= `APR_SEL_IDX_RST;
      gain_r                      <= {`APR_NCH{`APR_GAIN_UNITY}};
      assign_r                    <= {`APR_NCH*`APR_NCH{1'b0}};
      for (r = 0; r < `APR_NCH; r = r + 1)
        assign_r[r*17] <= 1'b1; // [RULE_17]
    end
    else if (access & pwrite)
    begin
      if (paddr == `APR_OFS_CTRL)
        global_level_ctrl_switch_r <= pwdata[`APR_CTRL_SWITCH];
      if (paddr == `APR_OFS_LEVEL_EN)
        channel_level_ctrl_enable_r <= pwdata[`APR_NCH-1:0];
      if (paddr == `APR_OFS_DATA_MODE)
        data_mode_r <= pwdata[`APR_NPAIR-1:0];
      if (sel_hit & ok0) // [RULE_15]
      begin
        sel_type_r[grp*4 +: 2] <= pwdata[`APR_SEL0_TYPE_LSB +: 2];
        sel_idx_r[grp*6 +: 3]  <= pwdata[`APR_SEL0_IDX_LSB +: 3];
      end
      if (sel_hit & ok1) // [RULE_15]
      begin
        sel_type_r[grp*4+2 +: 2] <= pwdata[`APR_SEL1_TYPE_LSB +: 2];
        sel_idx_r[grp*6+3 +: 3]  <= pwdata[`APR_SEL1_IDX_LSB +: 3];
      end
      if (gain_hit)
        gain_r[grp*32 +: 32] <= pwdata;
      if (asg_hit)
        assign_r[paddr[5:2]*16 +: 16] <= pwdata[15:0]; // [RULE_17]
    end
  end

  // read mux
  always @*
  begin
    rd_nxt = 32'h0000_0000;
    if (paddr == `APR_OFS_CTRL)
      rd_nxt[`APR_CTRL_SWITCH] = global_level_ctrl_switch_r;
    else if (paddr == `APR_OFS_STATUS)
      rd_nxt = {8'h00, 4'h0, AES_LIM, aes_oe, aes_used};
    else if (paddr == `APR_OFS_LEVEL_EN)
      rd_nxt[`APR_NCH-1:0] = channel_level_ctrl_enable_r;
    else if (paddr == `APR_OFS_DATA_MODE)
      rd_nxt[`APR_NPAIR-1:0] = data_mode_r;
    else if (sel_hit)
    begin
      rd_nxt[`APR_SEL0_TYPE_LSB +: 2] = sel_type_r[grp*4 +: 2];
      rd_nxt[`APR_SEL0_IDX_LSB +: 3]  = sel_idx_r[grp*6 +: 3];
      rd_nxt[`APR_SEL1_TYPE_LSB +: 2] = sel_type_r[grp*4+2 +: 2];
      rd_nxt[`APR_SEL1_IDX_LSB +: 3]  = sel_idx_r[grp*6+3 +: 3];
    end
    else if (gain_hit)
      rd_nxt = gain_r[grp*32 +: 32];
    else if (asg_hit)
      rd_nxt[15:0] = assign_r[paddr[5:2]*16 +: 16];
  end

  // read data captured in the setup cycle
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      prdata <= 32'h0000_0000;
    else if (setup & ~pwrite)
      prdata <= rd_nxt;
  end

  // decoder pair 7/8 silent in six-channel format
  always @*
  begin
    dec_gated = dec_in;
    if (!dec_eight_ch)
      dec_gated[`APR_DEC_CH*`APR_SW-1:6*`APR_SW] = {2*`APR_SW{1'b0}}; // [RULE_11]
  end

  // eight pair selectors, four groups of two
  genvar s;
  generate
    for (s = 0; s < `APR_NPAIR; s = s + 1)
    begin : g_sel
      apr_pair_sel u_sel // [RULE_05] [RULE_06]
      (
        .clk         (clk),
        .reset_n     (reset_n),
        .pair_strobe (pair_strobe),
        .cfg_type    (sel_type_r[s*2 +: 2]),
        .cfg_idx     (sel_idx_r[s*3 +: 3]),
        .sdi_in      (sdi_in),
        .aes_in      (aes_in),
        .ana_in      (ana_in),
        .dec_in      (dec_gated),
        .act_type_r  (act_type[s*2 +: 2]),
        .act_idx_r   (act_idx[s*3 +: 3]),
        .ch_lo_r     (mix_in[2*s*`APR_SW +: `APR_SW]),
        .ch_hi_r     (mix_in[(2*s+1)*`APR_SW +: `APR_SW])
      );
    end
  endgenerate

  // connectors taken as inputs by any applied selection
  always @*
  begin
    aes_used = {`APR_NPAIR{1'b0}};
    for (i = 0; i < `APR_NPAIR; i = i + 1)
      if (act_type[i*2 +: 2] == `APR_SRC_AES)
        aes_used[act_idx[i*3 +: 3]] = 1'b1;
  end

  // output enable per connector, exclusive of input use
  always @*
  begin
    for (j = 0; j < `APR_NPAIR; j = j + 1)
      aes_oe[j] = ~aes_used[j] & (j < AES_PAIRS); // [RULE_03]
  end

  // mixer: per-input gain, bus assignment, saturating sum
  always @*
  begin
    mix_out = {`APR_NCH*`APR_SW{1'b0}};
    acc     = 40'sd0;
    prod    = 40'sd0;
    for (b = 0; b < `APR_NCH; b = b + 1)
    begin
      acc = 40'sd0;
      for (m = 0; m < `APR_NCH; m = m + 1)
      begin
        prod = $signed(mix_in[m*`APR_SW +: `APR_SW]) * $signed({1'b0, gain_r[m*8 +: 8]}); // [RULE_18]
        if (assign_r[m*16 + b] & ~data_mode_r[m/2]) // [RULE_17]
          acc = acc + (prod >>> `APR_GAIN_SHIFT);
      end
      if (data_mode_r[b/2])
        mix_out[b*`APR_SW +: `APR_SW] = mix_in[b*`APR_SW +: `APR_SW]; // [RULE_19]
      else if (acc > 40'sh00007fffff)
        mix_out[b*`APR_SW +: `APR_SW] = 24'h7fffff;
      else if (acc < -40'sh0000800000)
        mix_out[b*`APR_SW +: `APR_SW] = 24'h800000;
      else
        mix_out[b*`APR_SW +: `APR_SW] = acc[`APR_SW-1:0];
    end
  end

  // output stage, one cycle after the pair boundary
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      strobe_d_r <= 1'b0;
      out_strobe <= 1'b0;
      emb_out    <= {`APR_NCH*`APR_SW{1'b0}};
      aes_out    <= {`APR_NCH*`APR_SW{1'b0}};
      ana_out    <= {`APR_ANA_CH*`APR_SW{1'b0}};
    end
    else
    begin
      strobe_d_r <= pair_strobe;
      out_strobe <= strobe_d_r;
      if (strobe_d_r)
      begin
        emb_out <= mix_out; // [RULE_02] [RULE_13]
        aes_out <= mix_out; // [RULE_02] [RULE_04]
        ana_out <= mix_out[`APR_ANA_CH*`APR_SW-1:0]; // [RULE_04]
      end
    end
  end

  // effective level control enables for the gain engine
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      level_ctrl_active <= {`APR_NCH{1'b0}};
    else
      level_ctrl_active <= channel_level_ctrl_enable_r &
                           {`APR_NCH{global_level_ctrl_switch_r}}; // [RULE_01]
  end

endmodule

// >>> verification/apr_far_side.sv
`timescale 1ns/1ps
`include "apr_regs.vh"
module apr_far_side
(
  input  wire                           clk,
  input  wire                           reset_n,
  input  wire [`APR_NPAIR-1:0]          aes_oe,
  output reg                            pair_strobe,
  output wire [`APR_NCH*`APR_SW-1:0]    sdi_in,
  output wire [`APR_NCH*`APR_SW-1:0]    aes_in,
  output wire [`APR_ANA_CH*`APR_SW-1:0] ana_in,
  output wire [`APR_DEC_CH*`APR_SW-1:0] dec_in
);
  reg [1:0] div_r;
  // sample tagged by source and channel, always positive
  function automatic [23:0] smp(input [3:0] src, input [3:0] ch);
    smp = {src, 4'h0, ch, 12'h3c5};
  endfunction
  // sample-pair boundary every fourth clock
  always @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      div_r <= 2'h0;
      pair_strobe <= 1'b0;
    end
    else
    begin
      div_r <= div_r + 2'h1;
      pair_strobe <= (div_r == 2'h3);
    end
  end
  // per-channel sources; a connector the router drives shows inverted level
  genvar k;
  generate
    for (k = 0; k < 16; k = k + 1)
    begin : g_ch
      assign sdi_in[k*24+:24] = smp(4'h1, 4'(k));
      assign aes_in[k*24+:24] = aes_oe[k/2] ? ~smp(4'h2, 4'(k)) : smp(4'h2, 4'(k));
      if (k < 4)
      begin : g_ana
        assign ana_in[k*24+:24] = smp(4'h3, 4'(k));
      end
      if (k < 8)
      begin : g_dec
        assign dec_in[k*24+:24] = smp(4'h4, 4'(k));
      end
    end
  endgenerate
endmodule

// >>> verification/apr_router_monitor.sv
`timescale 1ns/1ps
`include "apr_regs.vh"
module apr_router_monitor
#(
  parameter AES_PAIRS = 8
)
(
  input wire                        clk,
  input wire                        reset_n,
  input wire                        psel,
  input wire                        penable,
  input wire                        pwrite,
  input wire                        pslverr,
  input wire                        pair_strobe,
  input wire                        out_strobe,
  input wire [`APR_NPAIR-1:0]       aes_oe,
  input wire [`APR_NCH*`APR_SW-1:0] emb_out,
  input wire [`APR_NCH*`APR_SW-1:0] aes_out,
  input wire [`APR_ANA_CH*`APR_SW-1:0] ana_out
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // boundary, then outputs two edges later
  sequence s_upd;
    pair_strobe ##2 out_strobe;
  endsequence
  property p_lat; pair_strobe |-> s_upd; endproperty
  property p_cause; out_strobe |-> $past(pair_strobe, 2); endproperty
  property p_pulse; out_strobe |=> !out_strobe; endproperty
  property p_hold; $changed(emb_out) |-> out_strobe; endproperty
  property p_dest; emb_out == aes_out; endproperty
  property p_ana; ana_out == emb_out[`APR_ANA_CH*`APR_SW-1:0]; endproperty
  property p_oe_lim; (aes_oe >> AES_PAIRS) == 0; endproperty
  property p_oe_chg; $changed(aes_oe) |-> $past(pair_strobe); endproperty
  property p_err; pslverr |-> psel && penable && pwrite; endproperty
  a_lat: assert property (p_lat) else $error("late output update");
  a_cause: assert property (p_cause) else $error("update without boundary");
  a_pulse: assert property (p_pulse) else $error("output pulse too long");
  a_hold: assert property (p_hold) else $error("output moved off boundary");
  a_dest: assert property (p_dest) else $error("embedded and aes differ");
  a_ana: assert property (p_ana) else $error("analog path differs");
  a_oe_lim: assert property (p_oe_lim) else $error("absent connector driven");
  a_oe_chg: assert property (p_oe_chg) else $error("direction moved off boundary");
  a_err: assert property (p_err) else $error("error outside write access");
endmodule
bind apr_router apr_router_monitor #(.AES_PAIRS(AES_PAIRS)) u_mon (.clk(clk), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pwrite(pwrite), .pslverr(pslverr), .pair_strobe(pair_strobe),
  .out_strobe(out_strobe), .aes_oe(aes_oe), .emb_out(emb_out), .aes_out(aes_out),
  .ana_out(ana_out));

// >>> verification/tb_apr_router.sv
`timescale 1ns/1ps
`include "apr_regs.vh"
module tb_apr_router;
  reg          clk, reset_n, psel, penable, pwrite, dec_eight_ch, err, err6;
  wire         pslverr6;
  wire [7:0]   aes_oe6;
  reg  [11:0]  paddr;
  reg  [31:0]  pwdata, rd;
  wire [31:0]  prdata;
  wire         pready, pslverr, pair_strobe, out_strobe;
  wire [383:0] sdi_in, aes_in, emb_out, aes_out;
  wire [95:0]  ana_in, ana_out;
  wire [191:0] dec_in;
  wire [7:0]   aes_oe;
  wire [15:0]  level_ctrl_active;
  integer      fails, check_count, p;
  always #20 clk = ~clk;
  apr_far_side u_far (.clk(clk), .reset_n(reset_n), .aes_oe(aes_oe), .pair_strobe(pair_strobe),
    .sdi_in(sdi_in), .aes_in(aes_in), .ana_in(ana_in), .dec_in(dec_in));
  apr_router #(.AES_PAIRS(8)) dut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pair_strobe(pair_strobe), .dec_eight_ch(dec_eight_ch),
    .sdi_in(sdi_in), .aes_in(aes_in), .ana_in(ana_in), .dec_in(dec_in), .emb_out(emb_out),
    .aes_out(aes_out), .aes_oe(aes_oe), .ana_out(ana_out), .out_strobe(out_strobe),
    .level_ctrl_active(level_ctrl_active));
  // reduced variant, six connectors, sharing bus and sources
  apr_router #(.AES_PAIRS(6)) dut6 (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(), .pready(),
    .pslverr(pslverr6), .pair_strobe(pair_strobe), .dec_eight_ch(dec_eight_ch),
    .sdi_in(sdi_in), .aes_in(aes_in), .ana_in(ana_in), .dec_in(dec_in), .emb_out(),
    .aes_out(), .aes_oe(aes_oe6), .ana_out(), .out_strobe(), .level_ctrl_active());
  // compare and count
  task chk(input [383:0] exp, input [383:0] got, input string what);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        fails = fails + 1;
        $display("Error %s expected %h seen %h", what, exp, got);
      end
    end
  endtask
  // one apb transfer, held until pready
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rd = prdata;
      err = pslverr;
      err6 = pslverr6;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask
  task frames(input integer n);
    repeat (n)
    begin
      @(posedge clk);
      while (out_strobe !== 1'b1)
        @(posedge clk);
    end
  endtask
  task chk_pair(input integer q, input [3:0] src, input [3:0] ch);
    chk({u_far.smp(src, ch + 4'h1), u_far.smp(src, ch)}, emb_out[q*48+:48], "pair");
  endtask
  task t_reset;
    begin
      apb(0, 12'h004, 0);
      chk(32'h0008ff00, rd, "status");
      chk(8'h3f, aes_oe6, "oe6");
      apb(1, 12'hffc, 32'hffff_ffff);
      chk(0, err, "slverr");
      apb(0, 12'hffc, 0);
      chk(0, {rd, err}, "unmapped");
    end
  endtask
  task t_route;
    begin
      apb(1, 12'h010, 32'h151c);
      apb(1, 12'h014, 32'h0b06);
      apb(1, 12'h018, 32'h0001);
      apb(1, 12'h01c, 32'h020f);
      chk(0, err, "slverr");
      frames(3);
      for (p = 0; p < 8; p = p + 1)
        chk_pair(p, 32'h34124321 >> (p*4), 32'h060042ae >> (p*4));
      chk(8'hde, aes_oe, "oe");
      chk(8'h1e, aes_oe6, "oe6");
      apb(0, 12'h004, 0);
      chk(32'h0008de21, rd, "status");
    end
  endtask
  task t_dec6;
    begin
      @(posedge clk);
      dec_eight_ch <= 1'b0;
      frames(3);
      chk(0, emb_out[6*48+:48], "dec78");
      chk_pair(3, 4'h4, 4'h4);
      dec_eight_ch <= 1'b1;
    end
  endtask
  task t_illegal;
    begin
      apb(1, 12'h014, 32'h070a);
      chk(1, err, "slverr");
      apb(0, 12'h014, 0);
      chk(32'h0706, rd, "sel");
    end
  endtask
  task t_level;
    begin
      apb(1, 12'h008, 32'hffff);
      repeat (2) @(posedge clk);
      chk(0, level_ctrl_active, "level");
      apb(1, 12'h000, 32'h1);
      repeat (2) @(posedge clk);
      chk(16'hffff, level_ctrl_active, "level");
    end
  endtask
  task t_mix;
    begin
      apb(1, 12'h020, 32'h80808040);
      apb(1, 12'h044, 32'h0001);
      frames(3);
      chk({24'h0, (u_far.smp(1, 14) >> 1) + u_far.smp(1, 15)}, emb_out[47:0], "mix");
      apb(1, 12'h00c, 32'h1);
      frames(3);
      chk_pair(0, 4'h1, 4'he);
    end
  endtask
  // aes pair 13/14 legal on full variant only
  task t_reduced;
    begin
      apb(1, 12'h018, 32'h0019);
      chk(0, err, "slverr");
      chk(1, err6, "slverr6");
    end
  endtask
  task print_verdict;
    begin
      $display("checks %0d errors %0d", check_count, fails);
      if (fails == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // hang guard, far beyond the expected hundred or so cycles
  initial
  begin
    #200000;
    fails = fails + 1;
    print_verdict;
  end
  initial
  begin
    {clk, reset_n, psel, penable, pwrite, err, err6} = 7'h0;
    {paddr, pwdata, rd} = 0;
    dec_eight_ch = 1'b1;
    fails = 0;
    check_count = 0;
    repeat (10) @(posedge clk);
    reset_n <= 1'b1;
    t_reset;
    t_route;
    t_dec6;
    t_illegal;
    t_level;
    t_mix;
    t_reduced;
    print_verdict;
  end
endmodule
